// [rtl/mpec_pkg.sv]
// constants, types and input indices for the module power and event controller
// assumes a single 100 MHz clock and a synchronous active-low reset in every user
//
// Behaviour
// - power good high lets power-up proceed
// - power button acts on its falling edge
// - reset button low resets the module
// - battery low level is reported
// - resume input low requests wake-up
// - pending output warns before low-power entry
// - sleep-rail output removes power in S3-S5
// - soft-off output low in S4 and S5
// - sleep button falling edge sleeps or wakes
// - lid switch sleeps or wakes, selectable polarity
// - watchdog kick falling edge restarts countdown
// - missing kick raises watchdog expired
// - expired holds until clear, reset, power-down
// - thermal alarm low reported as throttle request
// - processor overheat forces trip and S5
package mpec_pkg;

  // clock rate and derived cycle counts
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // watchdog period in milliseconds, cycles derived in the top parameter
  localparam int unsigned WDT_PERIOD_MS = 1000;
  localparam int unsigned WDT_CNT_W = 32;

  // warning time before a low-power entry, least time so rounded up
  localparam int unsigned PEND_TIME_NS = 1000;
  localparam int unsigned PEND_CYC = (PEND_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PEND_W = 8;

  // positions of the pin inputs in the synchroniser vector
  localparam int unsigned IN_PG = 0;
  localparam int unsigned IN_POWER_BUTTON_N = 1;
  localparam int unsigned IN_RESET_BUTTON_N = 2;
  localparam int unsigned IN_BATTERY_LOW_N = 3;
  localparam int unsigned IN_WAKE = 4;
  localparam int unsigned IN_SLPBTN = 5;
  localparam int unsigned IN_LID = 6;
  localparam int unsigned IN_KICK = 7;
  localparam int unsigned IN_THERMAL_ALARM_N = 8;
  localparam int unsigned N_IN = 9;

  // reset value of the synchronisers: power good low, active-low pins idle high
  localparam logic [N_IN-1:0] SYNC_RST = 9'h1FE;

  // power states
  typedef enum logic [5:0] {
    ST_OFF     = 6'h01,
    ST_WAIT_PG = 6'h02,
    ST_ON      = 6'h04,
    ST_PEND    = 6'h08,
    ST_SLEEP   = 6'h10,
    ST_HIBER   = 6'h20
  } mpec_state_e;

  // low-power target chosen when the warning starts
  typedef enum logic [2:0] {
    TGT_S3 = 3'h1,
    TGT_S4 = 3'h2,
    TGT_S5 = 3'h4
  } mpec_target_e;

endpackage

// [rtl/mpec_sync_if.sv]
// synchronised levels and edge pulses of the pin inputs
// assumes producer and consumer share the controller clock
`timescale 1ns/10ps
`default_nettype none
interface mpec_sync_if #(parameter int unsigned W = 9);
  logic [W-1:0] level;
  logic [W-1:0] fall;
  logic [W-1:0] rise;
  modport src (output level, output fall, output rise);
  modport dst (input level, input fall, input rise);
endinterface
`default_nettype wire

// [rtl/mpec_sync_edge.sv]
// two-flop synchroniser with edge detection for a vector of pin inputs
// assumes inputs are asynchronous; edges are seen two to three cycles late
`timescale 1ns/10ps
`default_nettype none
module mpec_sync_edge #(
  parameter int unsigned W = 9,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  mpec_sync_if.src o_sy
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // first stage feeds only the second; the edge logic looks at later stages
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // levels and one-cycle edge pulses
  assign o_sy.level = sync_q;
  assign o_sy.fall = prev_q & ~sync_q;
  assign o_sy.rise = ~prev_q & sync_q;

endmodule
`default_nettype wire

// [rtl/mpec_watchdog.sv]
// watchdog countdown with sticky expiry flag
// assumes kick, run and clear are single-clock-domain signals
`timescale 1ns/10ps
`default_nettype none
module mpec_watchdog
  import mpec_pkg::*;
#(
  parameter logic [mpec_pkg::WDT_CNT_W-1:0] P_CYCLES = 32'h05F5E100
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_kick,
  input wire logic i_clear,
  output logic o_expired
);

  logic [WDT_CNT_W-1:0] cnt_q;
  logic timeout;

  // expiry when the full period has passed without a kick
  assign timeout = i_run && !i_kick && (cnt_q == P_CYCLES - 1'b1);

  // counter restarts on a kick and stands at zero while stopped
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (!i_run || i_kick || timeout) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // a timeout in the clearing cycle wins, so no expiry is lost
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_expired <= 1'b0;
    end else if (timeout) begin
      o_expired <= 1'b1;
    end else if (i_clear) begin
      o_expired <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [rtl/mpec_top.sv]
// power-state and event controller of a plug-in computer module
// assumes carrier pins are asynchronous; software controls arrive on the mclk domain
`timescale 1ns/10ps
`default_nettype none
module mpec_top #(
  parameter int unsigned P_WDT_CYCLES = mpec_pkg::WDT_PERIOD_MS * mpec_pkg::CYC_PER_MS
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // carrier pins, all asynchronous
  input wire logic i_carrier_power_good,
  input wire logic i_power_button_n,
  input wire logic i_reset_button_n,
  input wire logic i_battery_low_n,
  input wire logic i_wake_n,
  input wire logic i_sleep_button_n,
  input wire logic i_lid_switch_n,
  input wire logic i_watchdog_kick_n,
  input wire logic i_thermal_alarm_n,
  // on-chip controls from software and the processor
  input wire logic i_lid_polarity,
  input wire logic i_sw_sleep_req,
  input wire logic i_sw_sleep_deep,
  input wire logic i_sw_off_req,
  input wire logic i_wdt_enable,
  input wire logic i_wdt_clear,
  input wire logic i_cpu_overheat,
  // carrier and system outputs
  output logic o_low_power_pending_n,
  output logic o_sleep_rail_off_n,
  output logic o_soft_off_n,
  output logic o_watchdog_expired,
  output logic o_thermal_trip_n,
  output logic o_battery_low,
  output logic o_thermal_throttle,
  output logic o_sys_reset_n,
  output logic [5:0] o_power_state
);
  import mpec_pkg::*;

  localparam logic [WDT_CNT_W-1:0] WDT_CYC = WDT_CNT_W'(P_WDT_CYCLES);
  localparam logic [PEND_W-1:0] PEND_LAST = PEND_W'(PEND_CYC - 1);

  mpec_sync_if #(.W(N_IN)) sy ();

  mpec_state_e state_q;
  mpec_state_e state_d;
  mpec_target_e target_q;
  mpec_target_e target_d;
  logic [PEND_W-1:0] pend_cnt_q;
  logic trip_q;
  logic pend_done;

  logic power_good;
  logic power_evt;
  logic reset_hold;
  logic wake_req;
  logic sleep_evt;
  logic lid_close;
  logic lid_open;
  logic kick_evt;
  logic powered;
  logic overheat_trip;
  logic wake_any;
  logic wdt_run;
  logic wdt_clear;
  logic rails_off_d;

  // every carrier pin passes the two-flop synchroniser before use
  mpec_sync_edge #(
    .W(N_IN),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_thermal_alarm_n, i_watchdog_kick_n, i_lid_switch_n, i_sleep_button_n,
              i_wake_n, i_battery_low_n,
              i_reset_button_n, i_power_button_n, i_carrier_power_good}),
    .o_sy(sy.src)
  );

  // decoded pin events; edges are used only where a level would retrigger
  assign power_good = sy.level[IN_PG];
  assign power_evt = sy.fall[IN_POWER_BUTTON_N];
  assign reset_hold = ~sy.level[IN_RESET_BUTTON_N];
  assign wake_req = ~sy.level[IN_WAKE];
  assign sleep_evt = sy.fall[IN_SLPBTN];
  assign kick_evt = sy.fall[IN_KICK];

  // polarity low: a low lid pin means closed; polarity high swaps the meaning
  assign lid_close = i_lid_polarity ? sy.rise[IN_LID] : sy.fall[IN_LID];
  assign lid_open = i_lid_polarity ? sy.fall[IN_LID] : sy.rise[IN_LID];

  // states in which the processor and its rails are live
  assign powered = (state_q == ST_WAIT_PG) || (state_q == ST_ON) || (state_q == ST_PEND);
  assign overheat_trip = powered && i_cpu_overheat;

  // any source that brings a sleeping system back
  assign wake_any = wake_req || power_evt || sleep_evt || lid_open;

  assign pend_done = (pend_cnt_q == PEND_LAST);

  // next power state; overheat outranks everything, then power-good loss, then reset, then user events
  always_comb begin
    state_d = state_q;
    target_d = target_q;
    if (overheat_trip) begin
      state_d = ST_OFF;
      target_d = TGT_S5;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          // a tripped system waits for a deliberate power button press
          if (power_evt || (wake_req && !trip_q)) begin
            state_d = ST_WAIT_PG;
          end
        end
        ST_WAIT_PG: begin
          // rails are requested; proceed only once the carrier reports them good
          if (power_good && !reset_hold) begin
            state_d = ST_ON;
          end
        end
        ST_ON: begin
          if (!power_good) begin
            state_d = ST_OFF;
            target_d = TGT_S5;
          end else if (reset_hold) begin
            state_d = ST_WAIT_PG;
          end else if (power_evt || i_sw_off_req) begin
            state_d = ST_PEND;
            target_d = TGT_S5;
          end else if (sleep_evt || lid_close || i_sw_sleep_req) begin
            state_d = ST_PEND;
            target_d = i_sw_sleep_deep ? TGT_S4 : TGT_S3;
          end
        end
        ST_PEND: begin
          // the warning runs its full time before the rails drop
          if (!power_good) begin
            state_d = ST_OFF;
            target_d = TGT_S5;
          end else if (pend_done) begin
            unique case (target_q)
              TGT_S3: state_d = ST_SLEEP;
              TGT_S4: state_d = ST_HIBER;
              TGT_S5: state_d = ST_OFF;
              default: state_d = ST_OFF;
            endcase
          end
        end
        ST_SLEEP: begin
          if (wake_any) begin
            state_d = ST_WAIT_PG;
          end
        end
        ST_HIBER: begin
          if (wake_any) begin
            state_d = ST_WAIT_PG;
          end
        end
        default: begin
          // an illegal code drops to the safe soft-off state
          state_d = ST_OFF;
          target_d = TGT_S5;
        end
      endcase
    end
  end

  // state register; reset lands in soft-off so the rails start dropped
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // target register, latched when the warning starts and read when it ends
  // keeping it apart lets software change the depth request mid-warning safely
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      target_q <= TGT_S5;
    end else begin
      target_q <= target_d;
    end
  end

  // warning timer, restarted on every entry to the pending state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pend_cnt_q <= '0;
    end else if (state_q != ST_PEND) begin
      pend_cnt_q <= '0;
    end else if (!pend_done) begin
      pend_cnt_q <= pend_cnt_q + 1'b1;
    end
  end

  // trip latch: set wins over the clear from a power button press
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      trip_q <= 1'b0;
    end else if (overheat_trip) begin
      trip_q <= 1'b1;
    end else if (state_q == ST_OFF && power_evt) begin
      trip_q <= 1'b0;
    end
  end

  // rails drop in S3, S4 and S5 alike
  assign rails_off_d = (state_d == ST_OFF) || (state_d == ST_SLEEP) || (state_d == ST_HIBER);

  // watchdog runs only while the system is live and out of reset
  assign wdt_run = i_wdt_enable && (state_q == ST_ON) && !reset_hold;
  // software clear, a system reset or a power-down each release the flag
  assign wdt_clear = i_wdt_clear || reset_hold || rails_off_d;

  mpec_watchdog #(
    .P_CYCLES(WDT_CYC)
  ) u_wdt (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_run(wdt_run),
    .i_kick(kick_evt),
    .i_clear(wdt_clear),
    .o_expired(o_watchdog_expired)
  );

  // warning pin, low for the whole pending state
  // registered from the next state so it moves on the same edge as the state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_low_power_pending_n <= 1'b1;
    end else begin
      o_low_power_pending_n <= (state_d != ST_PEND);
    end
  end

  // sleep-rail pin; the carrier gates its main-derived rail enables with it
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sleep_rail_off_n <= 1'b0;
    end else begin
      o_sleep_rail_off_n <= !rails_off_d;
    end
  end

  // soft-off pin, low in S4 and S5 but not in S3
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_soft_off_n <= 1'b0;
    end else begin
      o_soft_off_n <= !((state_d == ST_OFF) || (state_d == ST_HIBER));
    end
  end

  // system reset released only while live and the button is not held
  // waiting for power good keeps the processor in reset until rails settle
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sys_reset_n <= 1'b0;
    end else begin
      o_sys_reset_n <= ((state_d == ST_ON) || (state_d == ST_PEND)) && !reset_hold;
    end
  end

  // one-hot state copy for software and debug
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_power_state <= ST_OFF;
    end else begin
      o_power_state <= state_d;
    end
  end

  // trip pin follows the latch so the carrier sees why the system went off
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_thermal_trip_n <= 1'b1;
    end else begin
      o_thermal_trip_n <= !(overheat_trip || trip_q);
    end
  end

  // battery report is a plain level, filtered only by the synchroniser
  // no debounce, so a chattering pin shows up here as it is
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_battery_low <= 1'b0;
    end else begin
      o_battery_low <= ~sy.level[IN_BATTERY_LOW_N];
    end
  end

  // thermal alarm passed on as a throttle request; throttling itself is elsewhere
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_thermal_throttle <= 1'b0;
    end else begin
      o_thermal_throttle <= ~sy.level[IN_THERMAL_ALARM_N];
    end
  end

endmodule
`default_nettype wire

// [testbench/mpec_top_sva.sv]
// checker on the power and event controller ports
// assumes one mclk domain; attached to every mpec_top by the bind below
`timescale 1ns/10ps
`default_nettype none
module mpec_top_sva (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_power_button_n,
  input wire logic i_reset_button_n,
  input wire logic i_battery_low_n,
  input wire logic i_wdt_clear,
  input wire logic i_cpu_overheat,
  input wire logic o_low_power_pending_n,
  input wire logic o_sleep_rail_off_n,
  input wire logic o_soft_off_n,
  input wire logic o_watchdog_expired,
  input wire logic o_thermal_trip_n,
  input wire logic o_battery_low,
  input wire logic o_sys_reset_n,
  input wire logic [5:0] o_power_state
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // rail pins follow the one-hot state
  property p_rail;
    o_sleep_rail_off_n == !(o_power_state inside {6'h01, 6'h10, 6'h20});
  endproperty
  a_rail: assert property (p_rail) else $error("rail pin vs state");
  property p_soft;
    o_soft_off_n == !(o_power_state inside {6'h01, 6'h20});
  endproperty
  a_soft: assert property (p_soft) else $error("soft-off pin vs state");
  // sleep or hibernate is only reached through the warning state
  property p_pend;
    (o_power_state inside {6'h10, 6'h20}) && !$stable(o_power_state)
      |-> $past(o_power_state) == 6'h08 && !$past(o_low_power_pending_n);
  endproperty
  a_pend: assert property (p_pend) else $error("no warning before sleep");
  property p_pwr;
    o_power_state == 6'h01 && $fell(i_power_button_n) |-> ##[2:4] o_power_state == 6'h02;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power press ignored");
  // margin of four samples covers the synchroniser delay
  property p_rst;
    (!i_reset_button_n)[*4] |-> !o_sys_reset_n;
  endproperty
  a_rst: assert property (p_rst) else $error("reset button ignored");
  property p_batt;
    $stable(i_battery_low_n)[*4] |-> o_battery_low == !i_battery_low_n;
  endproperty
  a_batt: assert property (p_batt) else $error("battery report wrong");
  property p_trip;
    i_cpu_overheat && (o_power_state inside {6'h02, 6'h04, 6'h08})
      |=> o_power_state == 6'h01 && !o_thermal_trip_n;
  endproperty
  a_trip: assert property (p_trip) else $error("overheat not tripped");
  // expiry flag drops only on clear, reset button or rails off
  property p_hold;
    o_watchdog_expired && !i_wdt_clear && i_reset_button_n && $past(i_reset_button_n)
      && $past(i_reset_button_n, 2) |=> o_watchdog_expired || !o_sleep_rail_off_n;
  endproperty
  a_hold: assert property (p_hold) else $error("expiry flag lost");
  c_sleep: cover property (o_power_state == 6'h10);
  c_hiber: cover property (o_power_state == 6'h20);
  c_wdt: cover property ($rose(o_watchdog_expired));
endmodule
bind mpec_top mpec_top_sva mpec_top_sva_i (.i_mclk, .i_rst_n, .i_power_button_n,
  .i_reset_button_n, .i_battery_low_n, .i_wdt_clear, .i_cpu_overheat, .o_low_power_pending_n,
  .o_sleep_rail_off_n, .o_soft_off_n, .o_watchdog_expired, .o_thermal_trip_n, .o_battery_low,
  .o_sys_reset_n, .o_power_state);
`default_nettype wire

// [testbench/mpec_carrier_model.sv]
// carrier rails and power-good source for the controller bench
// assumes rails follow the sleep-rail output after a fixed ramp
`timescale 1ns/10ps
`default_nettype none
module mpec_carrier_model #(
  parameter int unsigned P_RAMP = 12
) (
  input wire logic i_mclk,
  input wire logic i_sleep_rail_off_n,
  output logic o_power_good
);
  int unsigned ramp_q = 0;
  logic good_q = 1'b0;
  assign o_power_good = good_q;
  // rails gated by the sleep-rail pin, good only once ramped
  always @(posedge i_mclk) begin
    if (!i_sleep_rail_off_n) begin
      ramp_q <= 0;
      good_q <= 1'b0;
    end else begin
      if (ramp_q < P_RAMP) ramp_q <= ramp_q + 1;
      good_q <= (ramp_q >= P_RAMP);
    end
  end
endmodule
`default_nettype wire

// [testbench/mpec_top_tb.sv]
// self-checking bench of the power and event controller
// assumes the carrier model supplies power good; short watchdog period
`timescale 1ns/10ps
`default_nettype none
module mpec_top_tb;
  import mpec_pkg::*;
  localparam int unsigned WDT = 50;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_power_button_n = 1'b1, i_reset_button_n = 1'b1;
  logic i_battery_low_n = 1'b1, i_wake_n = 1'b1, i_sleep_button_n = 1'b1, i_lid_switch_n = 1'b1;
  logic i_watchdog_kick_n = 1'b1, i_thermal_alarm_n = 1'b1, i_lid_polarity = 1'b0;
  logic i_sw_sleep_req = 1'b0, i_sw_sleep_deep = 1'b0, i_sw_off_req = 1'b0, i_wdt_enable = 1'b0;
  logic i_wdt_clear = 1'b0, i_cpu_overheat = 1'b0, i_carrier_power_good;
  logic o_low_power_pending_n, o_sleep_rail_off_n, o_soft_off_n, o_watchdog_expired;
  logic o_thermal_trip_n, o_battery_low, o_thermal_throttle, o_sys_reset_n;
  logic [5:0] o_power_state;
  logic [31:0] r;
  int errors = 0, num_checks = 0, seed = 71157, n;

  mpec_top #(.P_WDT_CYCLES(WDT)) mpec_top_i (.i_mclk, .i_rst_n, .i_carrier_power_good,
    .i_power_button_n, .i_reset_button_n, .i_battery_low_n, .i_wake_n, .i_sleep_button_n,
    .i_lid_switch_n, .i_watchdog_kick_n, .i_thermal_alarm_n, .i_lid_polarity, .i_sw_sleep_req,
    .i_sw_sleep_deep, .i_sw_off_req, .i_wdt_enable, .i_wdt_clear, .i_cpu_overheat,
    .o_low_power_pending_n, .o_sleep_rail_off_n, .o_soft_off_n, .o_watchdog_expired,
    .o_thermal_trip_n, .o_battery_low, .o_thermal_throttle, .o_sys_reset_n, .o_power_state);
  mpec_carrier_model mpec_carrier_model_i (.i_mclk, .i_sleep_rail_off_n(o_sleep_rail_off_n),
    .o_power_good(i_carrier_power_good));

  // 100 MHz clock
  always #5 i_mclk = ~i_mclk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_mclk);
  endtask
  // expected pending, rail and soft-off pins for a state
  function automatic logic [7:0] pins_for(input logic [5:0] s);
    return {5'h0, s != 6'h08, !(s inside {6'h01, 6'h10, 6'h20}), !(s inside {6'h01, 6'h20})};
  endfunction
  // bounded wait for a state, then its pins
  task automatic wait_st(input logic [5:0] s);
    int k;
    k = 0;
    #1;
    while (o_power_state !== s && k < 400) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    chk({2'h0, o_power_state}, {2'h0, s});
    chk({5'h0, o_low_power_pending_n, o_sleep_rail_off_n, o_soft_off_n},
      pins_for(s));
  endtask
  task automatic set_pin(input int w, input logic v);
    case (w)
      0: i_power_button_n <= v;
      1: i_sleep_button_n <= v;
      2: i_wake_n <= v;
      default: i_watchdog_kick_n <= v;
    endcase
  endtask
  // low pulse of four cycles, long enough to pass the synchroniser
  task automatic press(input int w);
    @(posedge i_mclk);
    set_pin(w, 1'b0);
    cyc(4);
    set_pin(w, 1'b1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, the sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    report_and_stop();
  end

  // main sequence
  initial begin
    cyc(19);
    #1;
    chk({o_low_power_pending_n, o_sleep_rail_off_n, o_soft_off_n,
      o_watchdog_expired, o_thermal_trip_n, o_battery_low,
      o_thermal_throttle, o_sys_reset_n}, 8'h88);
    @(posedge i_mclk);
    i_rst_n <= 1'b1;
    press(0);
    wait_st(6'h02);
    wait_st(6'h04);
    chk({7'h0, o_sys_reset_n}, 8'h01);
    $display("done: power up");
    repeat (12) begin
      @(posedge i_mclk);
      r = $random(seed);
      i_battery_low_n <= r[0];
      i_thermal_alarm_n <= r[1];
      cyc(5);
      #1;
      chk({6'h0, o_battery_low, o_thermal_throttle}, {6'h0, !r[0], !r[1]});
    end
    @(posedge i_mclk);
    i_battery_low_n <= 1'b1;
    i_thermal_alarm_n <= 1'b1;
    i_wdt_enable <= 1'b1;
    $display("done: levels");
    repeat (5) begin
      r = $random(seed);
      cyc(20 + int'(r[2:0]));
      press(3);
      chk({7'h0, o_watchdog_expired}, 8'h00);
    end
    cyc(WDT - 10);
    chk({7'h0, o_watchdog_expired}, 8'h00);
    cyc(20);
    chk({7'h0, o_watchdog_expired}, 8'h01);
    cyc(8);
    chk({7'h0, o_watchdog_expired}, 8'h01);
    i_wdt_clear <= 1'b1;
    i_wdt_enable <= 1'b0;
    @(posedge i_mclk);
    i_wdt_clear <= 1'b0;
    cyc(2);
    chk({7'h0, o_watchdog_expired}, 8'h00);
    $display("done: watchdog");
    i_reset_button_n <= 1'b0;
    cyc(6);
    chk({7'h0, o_sys_reset_n}, 8'h00);
    i_reset_button_n <= 1'b1;
    wait_st(6'h04);
    press(1);
    wait_st(6'h08);
    n = 0;
    while (o_power_state === 6'h08 && n < 400) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk({7'h0, n + 1 >= PEND_CYC}, 8'h01);
    wait_st(6'h10);
    press(2);
    wait_st(6'h02);
    wait_st(6'h04);
    $display("done: sleep and wake");
    @(posedge i_mclk);
    i_lid_switch_n <= 1'b0;
    wait_st(6'h10);
    @(posedge i_mclk);
    i_lid_switch_n <= 1'b1;
    wait_st(6'h04);
    @(posedge i_mclk);
    i_lid_polarity <= 1'b1;
    i_lid_switch_n <= 1'b0;
    cyc(8);
    chk({2'h0, o_power_state}, 8'h04);
    i_sw_sleep_deep <= 1'b1;
    i_sw_sleep_req <= 1'b1;
    @(posedge i_mclk);
    i_sw_sleep_req <= 1'b0;
    wait_st(6'h20);
    press(1);
    wait_st(6'h04);
    $display("done: lid and hibernate");
    @(posedge i_mclk);
    i_cpu_overheat <= 1'b1;
    @(posedge i_mclk);
    i_cpu_overheat <= 1'b0;
    #1;
    chk({2'h0, o_power_state}, 8'h01);
    chk({7'h0, o_thermal_trip_n}, 8'h00);
    press(2);
    cyc(4);
    chk({2'h0, o_power_state}, 8'h01);
    press(0);
    wait_st(6'h04);
    @(posedge i_mclk);
    i_sw_off_req <= 1'b1;
    @(posedge i_mclk);
    i_sw_off_req <= 1'b0;
    wait_st(6'h08);
    wait_st(6'h01);
    $display("done: trip and soft off");
    report_and_stop();
  end
endmodule
`default_nettype wire
